// *** verilog/temp_alarm_pkg.sv ***
// register map, field layout, reset values and timing of the alarm monitor
package temp_alarm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int TEMP_W = 12;
	localparam int RES_W = 11;
	localparam int HYST_W = 8;
	localparam int OFFS_W = 8;
	localparam int NUM_LIM = 4;
	localparam int IRQ_W = 4;
	localparam int CFG_W = 7;
	localparam int BADDR_W = 7;
	localparam logic [ADDR_W-1:0] REG_LOCAL_RES = 8'h00;
	localparam logic [ADDR_W-1:0] REG_REMOTE_RES = 8'h01;
	localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h02;
	localparam logic [ADDR_W-1:0] REG_ONESHOT = 8'h03;
	localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h04;
	localparam logic [ADDR_W-1:0] REG_HYST = 8'h05;
	localparam logic [ADDR_W-1:0] REG_LIM_CRIT_LOC = 8'h06;
	localparam logic [ADDR_W-1:0] REG_LIM_CRIT_REM = 8'h07;
	localparam logic [ADDR_W-1:0] REG_LIM_OS_LOC = 8'h08;
	localparam logic [ADDR_W-1:0] REG_LIM_OS_REM = 8'h09;
	localparam logic [ADDR_W-1:0] REG_ALARM_MASK = 8'h0A;
	localparam logic [ADDR_W-1:0] REG_ALARM_STATE = 8'h0B;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0D;
	// config fields
	localparam int CFG_STANDBY = 0;
	localparam int CFG_UNSIGNED = 1;
	localparam int CFG_FILTER = 2;
	localparam int CFG_MODEL = 3;
	localparam int CFG_OS_EN = 4;
	localparam int CFG_RATE_LO = 5;
	localparam logic [CFG_W-1:0] CFG_RESET = 7'h40;
	// limit slots; odd slots watch the remote channel
	localparam int LIM_CRIT_LOC = 0;
	localparam int LIM_CRIT_REM = 1;
	localparam int LIM_OS_LOC = 2;
	localparam int LIM_OS_REM = 3;
	localparam logic [TEMP_W-1:0] LIM_CRIT_RESET = 12'h370;
	localparam logic [TEMP_W-1:0] LIM_OS_RESET = 12'h2A8;
	localparam logic [HYST_W-1:0] HYST_RESET = 8'h50;
	// alarm state register fields above the four alarm bits
	localparam int ST_CRIT_PIN = 4;
	localparam int ST_OS_PIN = 5;
	localparam int ST_BUSY = 6;
	localparam int ST_ADDR_LO = 7;
	localparam int ST_ADDR_DONE = 9;
	// interrupt status bits
	localparam int IRQ_CONV = 0;
	localparam int IRQ_CRIT = 1;
	localparam int IRQ_OS = 2;
	localparam int IRQ_TIMEOUT = 3;
	// saturation points
	localparam logic [TEMP_W-1:0] TEMP_MAX = 12'h7FF;
	localparam logic [TEMP_W-1:0] TEMP_MIN = 12'h800;
	localparam logic [RES_W-1:0] RES_SMAX = 11'h3FF;
	localparam logic [RES_W-1:0] RES_SMIN = 11'h400;
	localparam int FILT_SHIFT = 2;
	// address select levels; bus addresses are arbitrary values
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;
	localparam logic [BADDR_W-1:0] BADDR_LOW = 7'h48;
	localparam logic [BADDR_W-1:0] BADDR_MID = 7'h49;
	localparam logic [BADDR_W-1:0] BADDR_HIGH = 7'h4A;
	localparam logic [2:0] ADDR_SETTLE = 3'h4;
	// timing
	localparam int CLK_HZ = 50000000;
	localparam int CYC_PER_US = CLK_HZ / 1000000;
	localparam int PER_16HZ_US = 62500;
	localparam int PER_4HZ_US = 250000;
	localparam int PER_1HZ_US = 1000000;
	localparam int PER_0P4HZ_US = 2500000;
	localparam int TIMEOUT_US = 25000;
	localparam int PER_16HZ_CYC = PER_16HZ_US * CYC_PER_US;
	localparam int PER_4HZ_CYC = PER_4HZ_US * CYC_PER_US;
	localparam int PER_1HZ_CYC = PER_1HZ_US * CYC_PER_US;
	localparam int PER_0P4HZ_CYC = PER_0P4HZ_US * CYC_PER_US;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CYC_PER_US;
endpackage : temp_alarm_pkg

// *** verilog/dual_channel_temp_alarm_monitor.sv ***
// two-channel temperature result, limit and alarm pin logic
// Function
// - both channels give an 11-bit temperature result
// - results in signed -128..127.875 or unsigned 0..255.875 format
// - alarm pins assert when an unmasked channel exceeds its limit
// - software reads present alarm pin states in a status register
// - one hysteresis value is shared by all limits
// - remote result passes a configurable digital filter, local does not
// - model bit picks processor diode or discrete transistor
// - programmable offset adjusts the remote reading
// - after reset shared pin is a three-level address select input
// - up to three devices share a host, each with distinct address
// - shared pin as overtemp output is active low open drain
// - critical output is active low open drain, never drives high
// - both channels convert at a rate from 16 Hz to 0.4 Hz
// - standby stops periodic conversion; one-shot write in standby gives one conversion
// - bus is released when a transaction stalls past the timeout
`timescale 1ns/10ps
module dual_channel_temp_alarm_monitor #(
	parameter int unsigned PER_16HZ = temp_alarm_pkg::PER_16HZ_CYC,
	parameter int unsigned PER_4HZ = temp_alarm_pkg::PER_4HZ_CYC,
	parameter int unsigned PER_1HZ = temp_alarm_pkg::PER_1HZ_CYC,
	parameter int unsigned PER_0P4HZ = temp_alarm_pkg::PER_0P4HZ_CYC,
	parameter int unsigned TIMEOUT = temp_alarm_pkg::TIMEOUT_CYC
)(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// register port
	input wire logic [temp_alarm_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [temp_alarm_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [temp_alarm_pkg::DATA_W-1:0] reg_rdata_o,
	// converter front end
	output logic conv_start_o,
	output logic diode_model_o,
	input wire logic conv_done_i,
	input wire logic [temp_alarm_pkg::TEMP_W-1:0] local_raw_i,
	input wire logic [temp_alarm_pkg::TEMP_W-1:0] remote_raw_i,
	// shared address select / overtemp pin
	input wire logic address_select_in_high_i,
	input wire logic address_select_in_low_i,
	output logic overtemp_alarm_out_o,
	output logic overtemp_alarm_out_oe_o,
	// critical pin
	output logic critical_alarm_out_o,
	output logic critical_alarm_out_oe_o,
	// serial bus supervision
	input wire logic smb_clk_i,
	output logic bus_timeout_o,
	output logic [temp_alarm_pkg::BADDR_W-1:0] bus_address_o,
	output logic bus_address_valid_o,
	// interrupt
	output logic irq_o
);
	localparam int TW = temp_alarm_pkg::TEMP_W;
	localparam int RW = temp_alarm_pkg::RES_W;
	localparam int NL = temp_alarm_pkg::NUM_LIM;
	localparam int RATE_W = $clog2(PER_0P4HZ + 1);
	localparam int TO_W = $clog2(TIMEOUT + 1);

	if (PER_16HZ < 1 || PER_4HZ < PER_16HZ || PER_1HZ < PER_4HZ ||
		PER_0P4HZ < PER_1HZ || TIMEOUT < 2)
	begin : g_param_check
		$error("conversion periods must rise and timeout be at least 2");
	end

	typedef struct packed {
		logic [temp_alarm_pkg::DATA_W-1:0] rdata;
		logic [temp_alarm_pkg::CFG_W-1:0] cfg;
		logic [temp_alarm_pkg::OFFS_W-1:0] offset;
		logic [temp_alarm_pkg::HYST_W-1:0] hyst;
		logic [NL-1:0][TW-1:0] lim;
		logic [NL-1:0] amask;
		logic [NL-1:0] alarm;
		logic [temp_alarm_pkg::IRQ_W-1:0] irq_stat;
		logic [temp_alarm_pkg::IRQ_W-1:0] irq_mask;
		logic [TW-1:0] local_t;
		logic [TW-1:0] remote_t;
		logic [RW-1:0] local_res;
		logic [RW-1:0] remote_res;
		logic [RATE_W-1:0] rate_cnt;
		logic busy;
		logic start;
		logic pend;
		logic crit_pin;
		logic os_pin;
		logic [1:0] addr_s1;
		logic [1:0] addr_s2;
		logic [1:0] addr_sel;
		logic [temp_alarm_pkg::BADDR_W-1:0] bus_addr;
		logic [2:0] settle;
		logic addr_done;
		logic scl_s1;
		logic scl_s2;
		logic [TO_W-1:0] to_cnt;
		logic timeout;
	} state_s;

	state_s r;
	state_s next_r;

	function automatic logic [TW-1:0] sat_temp(input logic [TW:0] v);
		if (v[TW] != v[TW-1])
			return v[TW] ? temp_alarm_pkg::TEMP_MIN : temp_alarm_pkg::TEMP_MAX;
		return v[TW-1:0];
	endfunction : sat_temp

	function automatic logic [RW-1:0] fmt(input logic [TW-1:0] t,
		input logic uns);
		if (uns)
			return t[TW-1] ? '0 : t[RW-1:0];
		if (t[TW-1] != t[TW-2])
			return t[TW-1] ? temp_alarm_pkg::RES_SMIN : temp_alarm_pkg::RES_SMAX;
		return t[RW-1:0];
	endfunction : fmt

	// per-limit comparison with the shared hysteresis
	logic [NL-1:0] alarm_eval;
	for (genvar g = 0; g < NL; g++)
	begin : g_alarm
		logic [TW-1:0] src;
		logic signed [TW:0] t;
		logic signed [TW:0] l;
		logic signed [TW:0] low;
		assign src = (g % 2 == 1) ? r.remote_t : r.local_t;
		assign t = $signed({src[TW-1], src});
		assign l = $signed({r.lim[g][TW-1], r.lim[g]});
		assign low = l - $signed({{(TW + 1 - temp_alarm_pkg::HYST_W){1'b0}},
			r.hyst});
		assign alarm_eval[g] = r.alarm[g] ? (t >= low) : (t > l);
	end

	logic [RATE_W-1:0] period;
	logic [TW:0] rem_sum;
	logic [TW-1:0] rem_adj;
	logic [TW:0] filt_step;
	logic [TW:0] filt_new;
	logic done;
	logic tick;
	logic crit_act;
	logic os_act;
	logic os_wr;
	logic [1:0] sel_now;

	always_comb
	begin
		next_r = r;
		next_r.rdata = '0;
		done = conv_done_i && r.busy;
		unique case (r.cfg[temp_alarm_pkg::CFG_RATE_LO +: 2])
			2'h0: period = RATE_W'(PER_16HZ - 1);
			2'h1: period = RATE_W'(PER_4HZ - 1);
			2'h2: period = RATE_W'(PER_1HZ - 1);
			2'h3: period = RATE_W'(PER_0P4HZ - 1);
		endcase
		// conversion scheduling
		tick = 1'b0;
		if (r.cfg[temp_alarm_pkg::CFG_STANDBY])
			next_r.rate_cnt = '0;
		else if (r.rate_cnt >= period)
		begin
			next_r.rate_cnt = '0;
			tick = 1'b1;
		end
		else
			next_r.rate_cnt = r.rate_cnt + 1'b1;
		os_wr = reg_wr_i && reg_addr_i == temp_alarm_pkg::REG_ONESHOT &&
			r.cfg[temp_alarm_pkg::CFG_STANDBY];
		next_r.start = (tick || r.pend) && !r.busy;
		next_r.pend = (r.pend && !next_r.start) || os_wr;
		next_r.busy = (r.busy && !conv_done_i) || next_r.start;
		// result path; offset and filter apply to remote only
		rem_sum = {remote_raw_i[TW-1], remote_raw_i} +
			{{(TW + 1 - temp_alarm_pkg::OFFS_W)
			{r.offset[temp_alarm_pkg::OFFS_W-1]}}, r.offset};
		rem_adj = sat_temp(rem_sum);
		filt_step = $unsigned($signed({rem_adj[TW-1], rem_adj} -
			{r.remote_t[TW-1], r.remote_t}) >>> temp_alarm_pkg::FILT_SHIFT);
		filt_new = {r.remote_t[TW-1], r.remote_t} + filt_step;
		if (done)
		begin
			next_r.local_t = local_raw_i;
			next_r.remote_t = r.cfg[temp_alarm_pkg::CFG_FILTER] ?
				filt_new[TW-1:0] : rem_adj;
			next_r.local_res = fmt(local_raw_i,
				r.cfg[temp_alarm_pkg::CFG_UNSIGNED]);
			next_r.remote_res = fmt(next_r.remote_t,
				r.cfg[temp_alarm_pkg::CFG_UNSIGNED]);
		end
		// alarms and pins
		next_r.alarm = alarm_eval;
		crit_act = |(r.alarm[temp_alarm_pkg::LIM_CRIT_REM:0] &
			~r.amask[temp_alarm_pkg::LIM_CRIT_REM:0]);
		os_act = |(r.alarm[NL-1:temp_alarm_pkg::LIM_OS_LOC] &
			~r.amask[NL-1:temp_alarm_pkg::LIM_OS_LOC]);
		next_r.crit_pin = crit_act;
		next_r.os_pin = os_act && r.cfg[temp_alarm_pkg::CFG_OS_EN] &&
			r.addr_done;
		// address select sampled once after reset
		next_r.addr_s1 = {address_select_in_high_i, address_select_in_low_i};
		next_r.addr_s2 = r.addr_s1;
		if (r.addr_s2[1])
			sel_now = temp_alarm_pkg::SEL_HIGH;
		else if (r.addr_s2[0])
			sel_now = temp_alarm_pkg::SEL_LOW;
		else
			sel_now = temp_alarm_pkg::SEL_MID;
		if (!r.addr_done)
		begin
			next_r.settle = r.settle + 1'b1;
			if (r.settle == temp_alarm_pkg::ADDR_SETTLE)
			begin
				next_r.addr_done = 1'b1;
				next_r.addr_sel = sel_now;
				unique case (sel_now)
					temp_alarm_pkg::SEL_HIGH:
						next_r.bus_addr = temp_alarm_pkg::BADDR_HIGH;
					temp_alarm_pkg::SEL_LOW:
						next_r.bus_addr = temp_alarm_pkg::BADDR_LOW;
					default:
						next_r.bus_addr = temp_alarm_pkg::BADDR_MID;
				endcase
			end
		end
		// clock-low timeout supervision
		next_r.scl_s1 = smb_clk_i;
		next_r.scl_s2 = r.scl_s1;
		next_r.timeout = 1'b0;
		if (r.scl_s2)
			next_r.to_cnt = '0;
		else if (r.to_cnt != TO_W'(TIMEOUT))
		begin
			next_r.to_cnt = r.to_cnt + 1'b1;
			next_r.timeout = r.to_cnt == TO_W'(TIMEOUT - 1);
		end
		// register writes
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				temp_alarm_pkg::REG_CONFIG:
					next_r.cfg = reg_wdata_i[temp_alarm_pkg::CFG_W-1:0];
				temp_alarm_pkg::REG_OFFSET:
					next_r.offset = reg_wdata_i[temp_alarm_pkg::OFFS_W-1:0];
				temp_alarm_pkg::REG_HYST:
					next_r.hyst = reg_wdata_i[temp_alarm_pkg::HYST_W-1:0];
				temp_alarm_pkg::REG_LIM_CRIT_LOC:
					next_r.lim[temp_alarm_pkg::LIM_CRIT_LOC] = reg_wdata_i[TW-1:0];
				temp_alarm_pkg::REG_LIM_CRIT_REM:
					next_r.lim[temp_alarm_pkg::LIM_CRIT_REM] = reg_wdata_i[TW-1:0];
				temp_alarm_pkg::REG_LIM_OS_LOC:
					next_r.lim[temp_alarm_pkg::LIM_OS_LOC] = reg_wdata_i[TW-1:0];
				temp_alarm_pkg::REG_LIM_OS_REM:
					next_r.lim[temp_alarm_pkg::LIM_OS_REM] = reg_wdata_i[TW-1:0];
				temp_alarm_pkg::REG_ALARM_MASK:
					next_r.amask = reg_wdata_i[NL-1:0];
				temp_alarm_pkg::REG_IRQ_STATUS:
					next_r.irq_stat = r.irq_stat &
						~reg_wdata_i[temp_alarm_pkg::IRQ_W-1:0];
				temp_alarm_pkg::REG_IRQ_MASK:
					next_r.irq_mask = reg_wdata_i[temp_alarm_pkg::IRQ_W-1:0];
				default:
					next_r.cfg = r.cfg;
			endcase
		end
		// events win over a clear in the same cycle
		next_r.irq_stat[temp_alarm_pkg::IRQ_CONV] |= done;
		next_r.irq_stat[temp_alarm_pkg::IRQ_CRIT] |= crit_act && !r.crit_pin;
		next_r.irq_stat[temp_alarm_pkg::IRQ_OS] |= next_r.os_pin && !r.os_pin;
		next_r.irq_stat[temp_alarm_pkg::IRQ_TIMEOUT] |= next_r.timeout;
		// register reads
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				temp_alarm_pkg::REG_LOCAL_RES:
					next_r.rdata[RW-1:0] = r.local_res;
				temp_alarm_pkg::REG_REMOTE_RES:
					next_r.rdata[RW-1:0] = r.remote_res;
				temp_alarm_pkg::REG_CONFIG:
					next_r.rdata[temp_alarm_pkg::CFG_W-1:0] = r.cfg;
				temp_alarm_pkg::REG_OFFSET:
					next_r.rdata[temp_alarm_pkg::OFFS_W-1:0] = r.offset;
				temp_alarm_pkg::REG_HYST:
					next_r.rdata[temp_alarm_pkg::HYST_W-1:0] = r.hyst;
				temp_alarm_pkg::REG_LIM_CRIT_LOC:
					next_r.rdata[TW-1:0] = r.lim[temp_alarm_pkg::LIM_CRIT_LOC];
				temp_alarm_pkg::REG_LIM_CRIT_REM:
					next_r.rdata[TW-1:0] = r.lim[temp_alarm_pkg::LIM_CRIT_REM];
				temp_alarm_pkg::REG_LIM_OS_LOC:
					next_r.rdata[TW-1:0] = r.lim[temp_alarm_pkg::LIM_OS_LOC];
				temp_alarm_pkg::REG_LIM_OS_REM:
					next_r.rdata[TW-1:0] = r.lim[temp_alarm_pkg::LIM_OS_REM];
				temp_alarm_pkg::REG_ALARM_MASK:
					next_r.rdata[NL-1:0] = r.amask;
				temp_alarm_pkg::REG_ALARM_STATE:
				begin
					next_r.rdata[NL-1:0] = r.alarm;
					next_r.rdata[temp_alarm_pkg::ST_CRIT_PIN] = r.crit_pin;
					next_r.rdata[temp_alarm_pkg::ST_OS_PIN] = r.os_pin;
					next_r.rdata[temp_alarm_pkg::ST_BUSY] = r.busy;
					next_r.rdata[temp_alarm_pkg::ST_ADDR_LO +: 2] = r.addr_sel;
					next_r.rdata[temp_alarm_pkg::ST_ADDR_DONE] = r.addr_done;
				end
				temp_alarm_pkg::REG_IRQ_STATUS:
					next_r.rdata[temp_alarm_pkg::IRQ_W-1:0] = r.irq_stat;
				temp_alarm_pkg::REG_IRQ_MASK:
					next_r.rdata[temp_alarm_pkg::IRQ_W-1:0] = r.irq_mask;
				default:
					next_r.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			r <= '0;
			r.cfg <= temp_alarm_pkg::CFG_RESET;
			r.hyst <= temp_alarm_pkg::HYST_RESET;
			r.lim <= {temp_alarm_pkg::LIM_OS_RESET, temp_alarm_pkg::LIM_OS_RESET,
				temp_alarm_pkg::LIM_CRIT_RESET, temp_alarm_pkg::LIM_CRIT_RESET};
			r.scl_s1 <= 1'b1;
			r.scl_s2 <= 1'b1;
			r.bus_addr <= temp_alarm_pkg::BADDR_MID;
			r.addr_sel <= temp_alarm_pkg::SEL_MID;
		end
		else
			r <= next_r;
	end

	// open-drain pins only ever pull low
	assign critical_alarm_out_o = 1'b0;
	assign critical_alarm_out_oe_o = r.crit_pin;
	assign overtemp_alarm_out_o = 1'b0;
	assign overtemp_alarm_out_oe_o = r.os_pin;
	assign reg_rdata_o = r.rdata;
	assign conv_start_o = r.start;
	assign diode_model_o = r.cfg[temp_alarm_pkg::CFG_MODEL];
	assign bus_timeout_o = r.timeout;
	assign bus_address_o = r.bus_addr;
	assign bus_address_valid_o = r.addr_done;
	assign irq_o = |(r.irq_stat & r.irq_mask);

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	fmt_unsigned_a: assert property (
		done && r.cfg[temp_alarm_pkg::CFG_UNSIGNED] && local_raw_i[TW-1]
		|=> r.local_res == '0)
		else $error("negative local reading not clamped to zero");
	fmt_signed_a: assert property (
		done && !r.cfg[temp_alarm_pkg::CFG_UNSIGNED] &&
		local_raw_i[TW-1:TW-2] == 2'h1
		|=> r.local_res == temp_alarm_pkg::RES_SMAX)
		else $error("signed local result not saturated high");
	crit_pin_a: assert property (
		r.alarm[temp_alarm_pkg::LIM_CRIT_LOC] &&
		!r.amask[temp_alarm_pkg::LIM_CRIT_LOC] |=> critical_alarm_out_oe_o)
		else $error("unmasked critical alarm did not pull the pin");
	hyst_hold_a: assert property (
		r.alarm[0] && $signed({r.local_t[TW-1], r.local_t}) +
		$signed({{(TW + 1 - temp_alarm_pkg::HYST_W){1'b0}}, r.hyst}) >=
		$signed({r.lim[0][TW-1], r.lim[0]}) |=> r.alarm[0])
		else $error("alarm released above limit minus hysteresis");
	standby_a: assert property (
		r.cfg[temp_alarm_pkg::CFG_STANDBY] && !r.pend && !os_wr
		|=> !conv_start_o)
		else $error("conversion started in standby without one-shot");
	oneshot_a: assert property (
		os_wr && !r.busy && !r.pend |-> ##[1:2] conv_start_o)
		else $error("one-shot write gave no conversion");
	os_pin_a: assert property (
		overtemp_alarm_out_oe_o |-> bus_address_valid_o &&
		$past(r.cfg[temp_alarm_pkg::CFG_OS_EN]))
		else $error("overtemp pin driven before address sampled");
	addr_hold_a: assert property (
		bus_address_valid_o |=> $stable(bus_address_o) && bus_address_valid_o)
		else $error("bus address changed after sampling");
	timeout_a: assert property (
		!r.scl_s2 && r.to_cnt == TO_W'(TIMEOUT - 1) |=> bus_timeout_o)
		else $error("stalled clock did not raise timeout");
	status_rd_a: assert property (
		reg_rd_i && reg_addr_i == temp_alarm_pkg::REG_ALARM_STATE
		|=> reg_rdata_o[temp_alarm_pkg::ST_CRIT_PIN] ==
		$past(critical_alarm_out_oe_o))
		else $error("status read disagrees with critical pin");

	periodic_c: cover property (tick ##1 conv_start_o);
	oneshot_c: cover property (os_wr ##[1:2] conv_start_o);
	crit_c: cover property ($rose(critical_alarm_out_oe_o));
	timeout_c: cover property (bus_timeout_o);
endmodule : dual_channel_temp_alarm_monitor

// *** sim/front_end_model.sv ***
// converter front end that answers each start after a fixed delay
`timescale 1ns/10ps
module front_end_model #(
	parameter int DLY = 3
)(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// request and temperatures to report
	input wire logic conv_start_i,
	input wire logic [11:0] local_temp_i,
	input wire logic [11:0] remote_temp_i,
	// answer
	output logic conv_done_o,
	output logic [11:0] local_raw_o,
	output logic [11:0] remote_raw_o
);
	int cnt;
	logic [11:0] loc_q;
	logic [11:0] rem_q;
	// raw lines carry junk outside the done cycle
	assign local_raw_o = conv_done_o ? loc_q : ~loc_q;
	assign remote_raw_o = conv_done_o ? rem_q : ~rem_q;
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt <= 0;
			conv_done_o <= 1'b0;
			loc_q <= 12'h000;
			rem_q <= 12'h000;
		end
		else
		begin
			conv_done_o <= (cnt == 1);
			if (conv_start_i)
			begin
				cnt <= DLY;
				loc_q <= local_temp_i;
				rem_q <= remote_temp_i;
			end
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule : front_end_model

// *** sim/tb_top.sv ***
// self-checking bench of the two-channel alarm monitor
`timescale 1ns/10ps
module tb_top;
	localparam int PER [4] = '{20, 40, 80, 160};
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic conv_start_o, diode_model_o, conv_done_i;
	logic [11:0] local_raw_i, remote_raw_i;
	logic [11:0] loc_t = 12'h000;
	logic [11:0] rem_t = 12'h000;
	logic sel_high = 1'b1;
	logic sel_low = 1'b0;
	logic smb_clk_i = 1'b1;
	logic os_o, os_oe, crit_o, crit_oe, bus_timeout_o, addr_ok, irq_o;
	logic [6:0] bus_address_o;
	int n_errors = 0;
	int checks_done = 0;
	int seed = 54348;
	int n_starts = 0;
	int n_tmo = 0;

	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		n_starts <= n_starts + int'(conv_start_o);
		n_tmo <= n_tmo + int'(bus_timeout_o);
	end

	dual_channel_temp_alarm_monitor #(
		.PER_16HZ(20), .PER_4HZ(40), .PER_1HZ(80), .PER_0P4HZ(160), .TIMEOUT(50)
	) dual_channel_temp_alarm_monitor_inst (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.conv_start_o(conv_start_o), .diode_model_o(diode_model_o),
		.conv_done_i(conv_done_i), .local_raw_i(local_raw_i),
		.remote_raw_i(remote_raw_i),
		.address_select_in_high_i(sel_high), .address_select_in_low_i(sel_low),
		.overtemp_alarm_out_o(os_o), .overtemp_alarm_out_oe_o(os_oe),
		.critical_alarm_out_o(crit_o), .critical_alarm_out_oe_o(crit_oe),
		.smb_clk_i(smb_clk_i), .bus_timeout_o(bus_timeout_o),
		.bus_address_o(bus_address_o), .bus_address_valid_o(addr_ok),
		.irq_o(irq_o)
	);
	front_end_model front_end_model_inst (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.conv_start_i(conv_start_o), .local_temp_i(loc_t),
		.remote_temp_i(rem_t), .conv_done_o(conv_done_i),
		.local_raw_o(local_raw_i), .remote_raw_o(remote_raw_i)
	);

	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rchk
	// one-shot conversion in standby, then let results reach the pins
	task automatic conv(input logic [11:0] l, input logic [11:0] r);
		int i;
		loc_t <= l;
		rem_t <= r;
		wr(temp_alarm_pkg::REG_ONESHOT, 16'h0001);
		i = 0;
		while (conv_done_i !== 1'b1 && i < 50)
		begin
			@(posedge clk_sys_i) #1 i++;
		end
		chk({15'h0, i < 50}, 16'h0001);
		repeat (4) @(posedge clk_sys_i);
	endtask : conv
	function automatic logic signed [12:0] sat(input logic signed [12:0] s);
		return (s > 13'sh7FF) ? 13'sh7FF : (s < -13'sh800) ? -13'sh800 : s;
	endfunction : sat
	function automatic logic [15:0] fmt(input logic signed [12:0] t,
		input logic uns);
		if (uns)
			return (t < 0) ? 16'h0000 : {5'h00, t[10:0]};
		if (t > 13'sh3FF)
			return 16'h03FF;
		if (t < -13'sh400)
			return 16'h0400;
		return {5'h00, t[10:0]};
	endfunction : fmt

	initial
	begin
		#(20 * 30000);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end

	initial
	begin
		logic [11:0] l, r;
		logic [7:0] o;
		logic u;
		logic [15:0] d;
		int s0;
		static logic [11:0] tt [6] = '{12'h100, 12'h110, 12'h0F8, 12'h0E0,
			12'h0B8, 12'h0A0};
		static logic [5:0] ce = 6'b011000;
		static logic [5:0] oe = 6'b111110;
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		chk({9'h0, bus_address_o}, {9'h0, temp_alarm_pkg::BADDR_HIGH});
		chk({15'h0, addr_ok}, 16'h0001);
		rchk(temp_alarm_pkg::REG_CONFIG, {9'h0, temp_alarm_pkg::CFG_RESET});
		rchk(temp_alarm_pkg::REG_HYST, {8'h0, temp_alarm_pkg::HYST_RESET});
		rchk(temp_alarm_pkg::REG_LIM_CRIT_LOC, 16'h0370);
		rchk(8'h20, 16'h0000);
		sel_high <= 1'b0;
		sel_low <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		chk({9'h0, bus_address_o}, {9'h0, temp_alarm_pkg::BADDR_HIGH});
		$display("test reset done");
		for (int c = 0; c < 4; c++)
		begin
			wr(temp_alarm_pkg::REG_CONFIG, {9'h0, c[1:0], 5'h00});
			s0 = n_starts;
			repeat (8 * PER[c]) @(posedge clk_sys_i);
			s0 = n_starts - s0;
			chk({15'h0, s0 >= 7 && s0 <= 9}, 16'h0001);
		end
		wr(temp_alarm_pkg::REG_CONFIG, 16'h0001);
		repeat (20) @(posedge clk_sys_i);
		s0 = n_starts;
		repeat (200) @(posedge clk_sys_i);
		chk(16'(n_starts - s0), 16'h0000);
		wr(temp_alarm_pkg::REG_ONESHOT, 16'h0001);
		repeat (20) @(posedge clk_sys_i);
		chk(16'(n_starts - s0), 16'h0001);
		$display("test rate done");
		for (int k = 0; k < 8; k++)
		begin
			l = k ? 12'($random(seed)) : 12'h7FF;
			r = k ? 12'($random(seed)) : 12'h800;
			o = k ? 8'($random(seed)) : 8'h80;
			u = k ? 1'($random(seed)) : k[0];
			wr(temp_alarm_pkg::REG_CONFIG, {14'h0, u, 1'b1});
			wr(temp_alarm_pkg::REG_OFFSET, {8'h0, o});
			conv(l, r);
			rchk(temp_alarm_pkg::REG_LOCAL_RES, fmt({l[11], l}, u));
			d = fmt(sat($signed({r[11], r}) + $signed({{5{o[7]}}, o})), u);
			rchk(temp_alarm_pkg::REG_REMOTE_RES, d);
		end
		$display("test results done");
		wr(temp_alarm_pkg::REG_OFFSET, 16'h0000);
		conv(12'h000, 12'h000);
		wr(temp_alarm_pkg::REG_CONFIG, 16'h000D);
		conv(12'h100, 12'h200);
		chk({15'h0, diode_model_o}, 16'h0001);
		rchk(temp_alarm_pkg::REG_LOCAL_RES, 16'h0100);
		rchk(temp_alarm_pkg::REG_REMOTE_RES, 16'h0080);
		conv(12'h100, 12'h200);
		rchk(temp_alarm_pkg::REG_REMOTE_RES, 16'h00E0);
		$display("test filter done");
		wr(temp_alarm_pkg::REG_CONFIG, 16'h0011);
		wr(temp_alarm_pkg::REG_HYST, 16'h0010);
		wr(temp_alarm_pkg::REG_LIM_CRIT_LOC, 16'h0100);
		wr(temp_alarm_pkg::REG_LIM_OS_LOC, 16'h00C0);
		for (int k = 0; k < 6; k++)
		begin
			conv(tt[k], 12'h000);
			chk({14'h0, crit_oe, os_oe}, {14'h0, ce[5-k], oe[5-k]});
			rd(temp_alarm_pkg::REG_ALARM_STATE, d);
			chk({14'h0, d[5:4]}, {14'h0, oe[5-k], ce[5-k]});
			chk({14'h0, crit_o, os_o}, 16'h0000);
		end
		wr(temp_alarm_pkg::REG_ALARM_MASK, 16'h0001);
		conv(12'h110, 12'h000);
		rd(temp_alarm_pkg::REG_ALARM_STATE, d);
		chk({14'h0, d[4], d[0]}, 16'h0001);
		chk({15'h0, crit_oe}, 16'h0000);
		rd(temp_alarm_pkg::REG_IRQ_STATUS, d);
		chk({14'h0, d[2:1]}, 16'h0003);
		$display("test alarms done");
		wr(temp_alarm_pkg::REG_IRQ_STATUS, 16'h000F);
		wr(temp_alarm_pkg::REG_IRQ_MASK, 16'h0001);
		#1 chk({15'h0, irq_o}, 16'h0000);
		conv(12'h000, 12'h000);
		chk({15'h0, irq_o}, 16'h0001);
		wr(temp_alarm_pkg::REG_IRQ_STATUS, 16'h0001);
		@(posedge clk_sys_i) #1 chk({15'h0, irq_o}, 16'h0000);
		wr(temp_alarm_pkg::REG_IRQ_MASK, 16'h0000);
		conv(12'h000, 12'h000);
		chk({15'h0, irq_o}, 16'h0000);
		rd(temp_alarm_pkg::REG_IRQ_STATUS, d);
		chk({15'h0, d[0]}, 16'h0001);
		$display("test irq done");
		smb_clk_i <= 1'b0;
		s0 = n_tmo;
		repeat (120) @(posedge clk_sys_i);
		chk(16'(n_tmo - s0), 16'h0001);
		smb_clk_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		rd(temp_alarm_pkg::REG_IRQ_STATUS, d);
		chk({15'h0, d[3]}, 16'h0001);
		$display("test timeout done");
		// reset again with the select pin low, then at mid level
		for (int m = 0; m < 2; m++)
		begin
			arst_n_i <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
			arst_n_i <= 1'b1;
			repeat (8) @(posedge clk_sys_i);
			chk({9'h0, bus_address_o}, {9'h0, (m ? temp_alarm_pkg::BADDR_MID :
				temp_alarm_pkg::BADDR_LOW)});
			rd(temp_alarm_pkg::REG_ALARM_STATE, d);
			chk({13'h0, d[9:7]}, {13'h0, 1'b1, (m ? temp_alarm_pkg::SEL_MID :
				temp_alarm_pkg::SEL_LOW)});
			sel_low <= 1'b0;
		end
		$display("test address done");
		end_sim();
	end
endmodule : tb_top
